// >>> shared/timer_pkg.sv
// shared constants, field positions and types for the dual timer block
// assumes a single 25 MHz clock and an sfr-style byte register port
package timer_pkg;
    // register offsets on the special-function register port
    localparam logic [7:0] ctrl_addr = 8'h88;
    localparam logic [7:0] mode_addr = 8'h89;
    localparam logic [7:0] t0_low_addr = 8'h8a;
    localparam logic [7:0] t1_low_addr = 8'h8b;
    localparam logic [7:0] t0_high_addr = 8'h8c;
    localparam logic [7:0] t1_high_addr = 8'h8d;
    localparam logic [7:0] reg_reset = 8'h00;
    // control register bit positions
    localparam int tf1_bit = 7;
    localparam int tr1_bit = 6;
    localparam int tf0_bit = 5;
    localparam int tr0_bit = 4;
    localparam int ie1_bit = 3;
    localparam int it1_bit = 2;
    localparam int ie0_bit = 1;
    localparam int it0_bit = 0;
    // per-timer nibble inside the mode register
    localparam int gate_bit = 3;
    localparam int ct_bit = 2;
    localparam int nib_width = 4;
    // mode encodings
    localparam logic [1:0] mode_prescale = 2'h0;
    localparam logic [1:0] mode_full = 2'h1;
    localparam logic [1:0] mode_reload = 2'h2;
    localparam logic [1:0] mode_hold = 2'h3;
    // prescale width in mode zero
    localparam logic [7:0] prescale_max = 8'h1f;
    // tick dividers
    localparam logic [3:0] div_slow = 4'hb;
    localparam logic [3:0] div_fast = 4'h3;
    // one timer's steering bits
    typedef struct packed {
        logic run;
        logic gate;
        logic count_sel;
        logic [1:0] mode;
        logic fast_div;
        logic hold_in_mode3;
    } timer_ctrl_t;
endpackage

// >>> rtl/timer_unit.sv
// one timer/counter: prescaler, source select, gating and the byte pair
// assumes synchronised pin inputs on the same clock
`timescale 1ns/10ps
module timer_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // steering
    input wire timer_pkg::timer_ctrl_t ctrl,
    input wire logic gate_pin,
    input wire logic count_fall,
    // software writes
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wr_data,
    // state
    output logic [7:0] low_q,
    output logic [7:0] high_q,
    output logic overflow
);
    logic [3:0] div_reg; // internal tick divider
    logic [7:0] low_next;
    logic [7:0] high_next;
    logic ovf_next;
    wire [3:0] div_top = ctrl.fast_div ? timer_pkg::div_fast : timer_pkg::div_slow;
    wire tick = (div_reg == div_top);
    wire src = ctrl.count_sel ? count_fall : tick;
    wire enable = ctrl.run && (!ctrl.gate || gate_pin);
    wire halted = ctrl.hold_in_mode3 && (ctrl.mode == timer_pkg::mode_hold);
    wire step = src && enable && !halted;

    // free running tick divider
    always_ff @(posedge clk) begin
        if (rst || tick) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    // count update per mode
    always_comb begin
        low_next = low_q;
        high_next = high_q;
        ovf_next = 1'b0;
        if (step) begin
            case (ctrl.mode)
                timer_pkg::mode_prescale: begin
                    if (low_q[4:0] == timer_pkg::prescale_max[4:0]) begin
                        low_next = {low_q[7:5], 5'h00};
                        high_next = high_q + 8'h01;
                        ovf_next = (high_q == 8'hff);
                    end else begin
                        low_next = low_q + 8'h01;
                    end
                end
                timer_pkg::mode_full: begin
                    {high_next, low_next} = {high_q, low_q} + 16'h0001;
                    ovf_next = ({high_q, low_q} == 16'hffff);
                end
                timer_pkg::mode_reload: begin
                    if (low_q == 8'hff) begin
                        low_next = high_q;
                        ovf_next = 1'b1;
                    end else begin
                        low_next = low_q + 8'h01;
                    end
                end
                default: begin
                    // timer zero in mode three runs its low byte as 8-bit
                    low_next = low_q + 8'h01;
                    ovf_next = (low_q == 8'hff);
                end
            endcase
        end
        if (wr_low) begin
            low_next = wr_data;
        end
        if (wr_high) begin
            high_next = wr_data;
        end
    end

    // count registers, kept while halted
    always_ff @(posedge clk) begin
        if (rst) begin
            low_q <= timer_pkg::reg_reset;
            high_q <= timer_pkg::reg_reset;
            overflow <= 1'b0;
        end else begin
            low_q <= low_next;
            high_q <= high_next;
            overflow <= ovf_next;
        end
    end
endmodule // timer_unit

// >>> rtl/dual_timer.sv
// two timer/counters plus external interrupt detection
// assumes an sfr port from the core on the same clock; pins asynchronous
`timescale 1ns/10ps
module dual_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // special-function register port
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // clock divide selects from the separate clock control register
    input wire logic timer_zero_clock_divide_select,
    input wire logic timer_one_clock_divide_select,
    // service routine vector acknowledges, one-cycle pulses
    input wire logic timer_zero_vector_ack,
    input wire logic timer_one_vector_ack,
    input wire logic ext_irq_zero_vector_ack,
    input wire logic ext_irq_one_vector_ack,
    // pins
    input wire logic ext_irq_zero_pin,
    input wire logic ext_irq_one_pin,
    input wire logic timer_zero_count_pin,
    input wire logic timer_one_count_pin,
    // flags out to interrupt logic
    output logic [3:0] irq_flags
);
    logic [7:0] ctrl_reg; // control and flags
    logic [7:0] ctrl_next;
    logic [7:0] mode_reg; // mode select
    logic [3:0] sync1_reg; // first synchroniser stage
    logic [3:0] sync2_reg; // second stage
    logic [3:0] prev_reg; // last synced value for edges
    logic [7:0] rdata_next;
    logic [7:0] low_q [2];
    logic [7:0] high_q [2];
    logic [1:0] ovf;
    timer_pkg::timer_ctrl_t tctrl [2];

    // decodes
    wire wr_ctrl = sfr_wr && (sfr_addr == timer_pkg::ctrl_addr);
    wire wr_mode = sfr_wr && (sfr_addr == timer_pkg::mode_addr);
    wire [3:0] fall = prev_reg & ~sync2_reg;
    wire [1:0] irq_pin = sync2_reg[1:0];
    wire [1:0] cnt_fall = fall[3:2];
    wire [1:0] div_sel = {timer_one_clock_divide_select, timer_zero_clock_divide_select};
    wire [1:0] wr_low = {sfr_wr && (sfr_addr == timer_pkg::t1_low_addr),
                         sfr_wr && (sfr_addr == timer_pkg::t0_low_addr)};
    wire [1:0] wr_high = {sfr_wr && (sfr_addr == timer_pkg::t1_high_addr),
                          sfr_wr && (sfr_addr == timer_pkg::t0_high_addr)};

    // pin synchronisers: bits 1:0 irq pins, 3:2 count pins
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= 4'hf;
            sync2_reg <= 4'hf;
            prev_reg <= 4'hf;
        end else begin
            sync1_reg <= {timer_one_count_pin, timer_zero_count_pin,
                          ext_irq_one_pin, ext_irq_zero_pin};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // per-timer steering and instance
    generate
        for (genvar i = 0; i < 2; i++) begin : g_timer
            assign tctrl[i].run = ctrl_reg[timer_pkg::tr0_bit + 2 * i];
            assign tctrl[i].gate = mode_reg[timer_pkg::gate_bit + timer_pkg::nib_width * i];
            assign tctrl[i].count_sel = mode_reg[timer_pkg::ct_bit + timer_pkg::nib_width * i];
            assign tctrl[i].mode = mode_reg[timer_pkg::nib_width * i +: 2];
            assign tctrl[i].fast_div = div_sel[i];
            assign tctrl[i].hold_in_mode3 = (i == 1);
            timer_unit timer_unit_i (
                .clk(clk),
                .rst(rst),
                .ctrl(tctrl[i]),
                .gate_pin(irq_pin[i]),
                .count_fall(cnt_fall[i]),
                .wr_low(wr_low[i]),
                .wr_high(wr_high[i]),
                .wr_data(sfr_wdata),
                .low_q(low_q[i]),
                .high_q(high_q[i]),
                .overflow(ovf[i])
            );
        end
    endgenerate

    // control register next value: software write, then hardware events
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = sfr_wdata;
        end
        // overflow flags: vector clears, overflow set wins
        if (timer_zero_vector_ack) begin
            ctrl_next[timer_pkg::tf0_bit] = 1'b0;
        end
        if (timer_one_vector_ack) begin
            ctrl_next[timer_pkg::tf1_bit] = 1'b0;
        end
        if (ovf[0]) begin
            ctrl_next[timer_pkg::tf0_bit] = 1'b1;
        end
        if (ovf[1]) begin
            ctrl_next[timer_pkg::tf1_bit] = 1'b1;
        end
        // external interrupt zero detect
        if (ctrl_next[timer_pkg::it0_bit]) begin
            if (ext_irq_zero_vector_ack) begin
                ctrl_next[timer_pkg::ie0_bit] = 1'b0;
            end
            if (fall[0]) begin
                ctrl_next[timer_pkg::ie0_bit] = 1'b1;
            end
        end else begin
            ctrl_next[timer_pkg::ie0_bit] = ~irq_pin[0];
        end
        // external interrupt one detect
        if (ctrl_next[timer_pkg::it1_bit]) begin
            if (ext_irq_one_vector_ack) begin
                ctrl_next[timer_pkg::ie1_bit] = 1'b0;
            end
            if (fall[1]) begin
                ctrl_next[timer_pkg::ie1_bit] = 1'b1;
            end
        end else begin
            ctrl_next[timer_pkg::ie1_bit] = ~irq_pin[1];
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        case (sfr_addr)
            timer_pkg::ctrl_addr: rdata_next = ctrl_next;
            timer_pkg::mode_addr: rdata_next = mode_reg;
            timer_pkg::t0_low_addr: rdata_next = low_q[0];
            timer_pkg::t1_low_addr: rdata_next = low_q[1];
            timer_pkg::t0_high_addr: rdata_next = high_q[0];
            timer_pkg::t1_high_addr: rdata_next = high_q[1];
            default: rdata_next = 8'h00;
        endcase
    end

    // registers and registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= timer_pkg::reg_reset;
            mode_reg <= timer_pkg::reg_reset;
            sfr_rdata <= 8'h00;
            irq_flags <= 4'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            if (wr_mode) begin
                mode_reg <= sfr_wdata;
            end
            sfr_rdata <= sfr_rd ? rdata_next : 8'h00;
            irq_flags <= {ctrl_next[timer_pkg::tf1_bit], ctrl_next[timer_pkg::tf0_bit],
                          ctrl_next[timer_pkg::ie1_bit], ctrl_next[timer_pkg::ie0_bit]};
        end
    end
endmodule // dual_timer

// >>> testbench/dual_timer_asserts.sv
// port assertions for the dual timer block
// assumes one clock domain; attached by the bind at the foot
`timescale 1ns/10ps
module dual_timer_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // acks, pin and flags
    input wire logic timer_one_vector_ack,
    input wire logic ext_irq_zero_vector_ack,
    input wire logic ext_irq_zero_pin,
    input wire logic [3:0] irq_flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] ctl_reg; // software copy of run and type bits
    logic [7:0] mode_reg; // software copy of the mode register
    wire ctl_wr = sfr_wr && sfr_addr == 8'h88;
    // shadow software writes only; hardware flags are not tracked
    always_ff @(posedge clk) begin
        ctl_reg <= rst ? 8'h00 : (ctl_wr ? sfr_wdata : ctl_reg);
        mode_reg <= rst ? 8'h00 : ((sfr_wr && sfr_addr == 8'h89) ? sfr_wdata : mode_reg);
    end
    chk_idle_rdata: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not zero while idle");
    chk_unmapped_read: assert property (sfr_rd && sfr_addr == 8'h8e |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_ctl_mirror: assert property (sfr_rd && sfr_addr == 8'h88 |=>
        {sfr_rdata[7], sfr_rdata[5], sfr_rdata[3], sfr_rdata[1]} == irq_flags)
        else $error("control read disagrees with flags");
    chk_mode_rw: assert property (sfr_wr && sfr_addr == 8'h89 ##2 sfr_rd && sfr_addr == 8'h89
        |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("mode readback wrong");
    chk_level_follow: assert property ((!ctl_reg[0] && $stable(ext_irq_zero_pin)) [*5]
        |-> irq_flags[0] == !ext_irq_zero_pin) else $error("level detect not inverse of pin");
    chk_edge_hold: assert property (ctl_reg[0] && irq_flags[0] && !ext_irq_zero_vector_ack
        && !ctl_wr |=> irq_flags[0]) else $error("edge detect dropped");
    chk_edge_ack: assert property ((ctl_reg[0] && ext_irq_zero_pin) [*5] ##0
        (ext_irq_zero_vector_ack && !ctl_wr) |=> !irq_flags[0]) else $error("edge ack ignored");
    // three cycles: a step taken on the halting write edge still flags one cycle later
    chk_halt_no_ovf: assert property ((!ctl_reg[4] && !ctl_wr) [*3] |-> !$rose(irq_flags[2]))
        else $error("halted timer zero overflowed");
    chk_hold_no_ovf: assert property ((mode_reg[5:4] == 2'h3 && !ctl_wr) [*3]
        |-> !$rose(irq_flags[3])) else $error("held timer one overflowed");
    chk_ovf_ack: assert property ((mode_reg[5:4] == 2'h3 && !ctl_wr) [*2] ##0
        timer_one_vector_ack |=> !irq_flags[3]) else $error("overflow ack ignored");
    cover property ($rose(irq_flags[2]));
    cover property ($rose(irq_flags[0]));
    cover property (sfr_rd && sfr_addr == 8'h8b);
endmodule // dual_timer_asserts
bind dual_timer dual_timer_asserts dual_timer_asserts_i (.clk(clk), .rst(rst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer_one_vector_ack(timer_one_vector_ack), .ext_irq_zero_vector_ack(ext_irq_zero_vector_ack),
    .ext_irq_zero_pin(ext_irq_zero_pin), .irq_flags(irq_flags));

// >>> testbench/count_pulser.sv
// far-side model of an external count pin
// assumes the pin idles high through a pull-up
`timescale 1ns/10ps
module count_pulser #(
    parameter int n_pulses = 5 // pulses per burst
) (
    // clock and trigger
    input wire logic clk,
    input wire logic go,
    // count pin
    output logic pin
);
    initial pin = 1'b1;
    // each pulse of a burst: low 3 cycles, high 3 cycles, so the synced edge is seen
    always @(posedge clk) begin
        if (go) begin
            repeat (n_pulses) begin
                pin <= 1'b0;
                repeat (3) @(posedge clk);
                pin <= 1'b1;
                repeat (3) @(posedge clk);
            end
        end
    end
endmodule // count_pulser

// >>> testbench/dual_timer_bench.sv
// self-checking bench for the dual timer block
// assumes count_pulser and the bound assertions
`timescale 1ns/10ps
module dual_timer_bench;
    logic clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, div0 = 1'b0, go = 1'b0;
    logic ack0 = 1'b0, ack1 = 1'b0, eack0 = 1'b0, pin0 = 1'b1, cnt1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, q, p;
    logic [3:0] irq_flags;
    int error_cnt = 0, n_tests = 0, cycles = 0;
    dual_timer dual_timer_i (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .timer_zero_clock_divide_select(div0), .timer_one_clock_divide_select(1'b0),
        .timer_zero_vector_ack(ack0), .timer_one_vector_ack(ack1),
        .ext_irq_zero_vector_ack(eack0), .ext_irq_one_vector_ack(eack0),
        .ext_irq_zero_pin(pin0), .ext_irq_one_pin(pin0), .timer_zero_count_pin(cnt1),
        .timer_one_count_pin(cnt1), .irq_flags(irq_flags));
    count_pulser count_pulser_i (.clk(clk), .go(go), .pin(cnt1));
    always #20 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        cyc(1);
        sfr_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_rd = 1'b1;
        sfr_addr = a;
        cyc(1);
        sfr_rd = 1'b0;
        d = sfr_rdata;
        cyc(1);
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // every register and one unmapped place read zero after reset
    task automatic t_reset();
        for (int a = 8'h88; a <= 8'h8e; a++) begin
            rd(8'(a), q);
            chk("reset value", 8'h00, q);
        end
    endtask
    // 16-bit overflow at divide by twelve, ack clear, halt keeps count
    task automatic t_full();
        wr(8'h89, 8'h01);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hff);
        wr(8'h88, 8'h10);
        cyc(9);
        chk("tf0 early", 8'h00, {7'h00, irq_flags[2]});
        cyc(26);
        chk("tf0 set", 8'h01, {7'h00, irq_flags[2]});
        ack0 = 1'b1;
        cyc(1);
        ack0 = 1'b0;
        cyc(1);
        chk("tf0 ack", 8'h00, {7'h00, irq_flags[2]});
        wr(8'h88, 8'h00);
        rd(8'h8a, q);
        cyc(30);
        rd(8'h8a, p);
        chk("halted low", q, p);
    endtask
    // gated reload mode at divide by four, then gate off
    task automatic t_gate();
        div0 = 1'b1;
        pin0 = 1'b0;
        wr(8'h89, 8'h0a);
        wr(8'h8c, 8'hf0);
        wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h10);
        cyc(20);
        rd(8'h8a, q);
        chk("gated low", 8'hfe, q);
        pin0 = 1'b1;
        cyc(14);
        rd(8'h8a, q);
        chk("reloaded low", 8'h01, {7'h00, q >= 8'hf0 && q <= 8'hf4});
        chk("tf0 reload", 8'h01, {7'h00, irq_flags[2]});
        pin0 = 1'b0;
        wr(8'h89, 8'h02);
        rd(8'h8a, q);
        cyc(8);
        rd(8'h8a, p);
        chk("ungated count", 8'h01, {7'h00, p != q});
        wr(8'h88, 8'h00);
    endtask
    // edge then level detection on both interrupt pins, driven together
    task automatic t_ext();
        pin0 = 1'b1;
        wr(8'h88, 8'h05);
        cyc(4);
        chk("edge idle", 8'h00, {6'h00, irq_flags[1:0]});
        pin0 = 1'b0;
        cyc(5);
        chk("edge set", 8'h03, {6'h00, irq_flags[1:0]});
        pin0 = 1'b1;
        cyc(5);
        chk("edge held", 8'h03, {6'h00, irq_flags[1:0]});
        eack0 = 1'b1;
        cyc(1);
        eack0 = 1'b0;
        cyc(1);
        chk("edge ack", 8'h00, {6'h00, irq_flags[1:0]});
        wr(8'h88, 8'h00);
        pin0 = 1'b0;
        cyc(5);
        chk("level low", 8'h03, {6'h00, irq_flags[1:0]});
        pin0 = 1'b1;
        cyc(5);
        chk("level high", 8'h00, {6'h00, irq_flags[1:0]});
    endtask
    // both timers count pin pulses, then mode three holds timer one only
    task automatic t_count();
        wr(8'h89, 8'h55);
        rd(8'h89, q);
        chk("mode readback", 8'h55, q);
        wr(8'h8b, 8'h00);
        wr(8'h8a, 8'h00);
        wr(8'h88, 8'h50);
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(40);
        rd(8'h8b, q);
        chk("pin count", 8'h05, q);
        rd(8'h8a, q);
        chk("pin count zero", 8'h05, q);
        wr(8'h89, 8'h75);
        ack1 = 1'b1;
        cyc(1);
        ack1 = 1'b0;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(40);
        rd(8'h8b, q);
        chk("mode3 hold", 8'h05, q);
        rd(8'h8a, q);
        chk("zero still counts", 8'h0a, q);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        cyc(20);
        rst = 1'b0;
        t_reset();
        t_full();
        t_gate();
        t_ext();
        t_count();
        tally_and_finish();
    end
endmodule // dual_timer_bench
